// ===== hdl/obd_consts.svh
// Option byte decoder constants: addresses, field positions, reset values, register offsets
`ifndef OBD_CONSTS_SVH
`define OBD_CONSTS_SVH

// Option storage byte addresses
`define OBD_ADDR_LVD 8'hc1
`define OBD_ADDR_CLK 8'hc2
`define OBD_ADDR_DBG 8'hc3

// Fields of the detector and reset pin byte
`define OBD_MODE_LSB 0
`define OBD_FINE_LSB 2
`define OBD_RSTSEL_BIT 4
`define OBD_COARSE_LSB 5
`define OBD_COARSE_TOP 7

// Fields of the flash and oscillator byte
`define OBD_FREQ_LSB 0
`define OBD_FLASH_LSB 6
`define OBD_CLK_FIXED_MASK 8'h30
`define OBD_CLK_FIXED_VAL 8'h20

// Fields of the debug byte
`define OBD_DBG_KEEP_BIT 0
`define OBD_DBG_EN_BIT 7
`define OBD_DBG_FIXED_MASK 8'h7e
`define OBD_DBG_FIXED_VAL 8'h04

// Reset values
`define OBD_RAW_RST 8'h00
`define OBD_ERR_RST 6'h00

// Register byte offsets on the bus
`define OBD_REG_STATUS 8'h00
`define OBD_REG_LVD 8'h04
`define OBD_REG_CLK 8'h08
`define OBD_REG_DBG 8'h0c
`define OBD_REG_ERR 8'h10
`define OBD_REG_RAW 8'h14

`endif

// ===== hdl/obd_pkg.sv
// Option byte decoder types
package obd_pkg;
    typedef enum logic [1:0] {obd_lvd_off, obd_lvd_int, obd_lvd_int_rst, obd_lvd_rst}
        obd_lvd_mode_type;
    typedef enum logic [1:0] {obd_flash_lv, obd_flash_hs, obd_flash_bad} obd_flash_type;
    typedef enum logic [2:0] {obd_f24, obd_f16, obd_f12, obd_f8, obd_f4, obd_f1, obd_fbad}
        obd_freq_type;
    typedef enum logic [2:0] {obd_ld_fetch, obd_ld_gap, obd_ld_apply, obd_ld_done}
        obd_ld_state_type;
endpackage

// ===== hdl/obd_lvd_decode.sv
// Combinational decode of the detector mode and threshold fields
`timescale 1ns/10ps
`include "obd_consts.svh"
module obd_lvd_decode (
    input wire logic [7:0] opt_byte,
    output obd_pkg::obd_lvd_mode_type lvd_mode,
    output logic [3:0] lvd_level,
    output logic lvd_bad
);
    logic [1:0] mode_f;
    logic [1:0] fine_f;
    logic [2:0] coarse_f;
    logic [1:0] coarse_idx;

    // Field extraction and level index
    assign mode_f = opt_byte[`OBD_MODE_LSB +: 2];
    assign fine_f = opt_byte[`OBD_FINE_LSB +: 2];
    assign coarse_f = opt_byte[`OBD_COARSE_LSB +: 3];
    assign coarse_idx = coarse_f[1:0] - 2'h1;

    // Mode and threshold selection, prohibited codes fall back to reset mode
    always_comb begin
        lvd_mode = obd_pkg::obd_lvd_rst;
        lvd_level = 4'h0;
        lvd_bad = 1'b0;
        if (mode_f[0] && coarse_f[2]) begin
            lvd_mode = obd_pkg::obd_lvd_off;
        end else if (mode_f == 2'h0 || coarse_f[2] || coarse_f[1:0] == 2'h0) begin
            lvd_bad = 1'b1;
        end else if (mode_f == 2'h2 && fine_f == 2'h3) begin
            lvd_bad = 1'b1;
        end else begin
            lvd_level = {coarse_idx, ~fine_f};
            case (mode_f)
                2'h1: lvd_mode = obd_pkg::obd_lvd_int;
                2'h2: lvd_mode = obd_pkg::obd_lvd_int_rst;
                default: lvd_mode = obd_pkg::obd_lvd_rst;
            endcase
        end
    end
endmodule

// ===== hdl/obd_clk_decode.sv
// Combinational decode of flash operating mode and fast oscillator frequency code
`timescale 1ns/10ps
`include "obd_consts.svh"
module obd_clk_decode (
    input wire logic [7:0] opt_byte,
    output obd_pkg::obd_flash_type flash_mode,
    output obd_pkg::obd_freq_type osc_freq,
    output logic over_limit
);
    logic [1:0] flash_f;
    logic [3:0] freq_f;

    // Field extraction
    assign flash_f = opt_byte[`OBD_FLASH_LSB +: 2];
    assign freq_f = opt_byte[`OBD_FREQ_LSB +: 4];

    // Flash mode codes
    always_comb begin
        case (flash_f)
            2'h2: flash_mode = obd_pkg::obd_flash_lv;
            2'h3: flash_mode = obd_pkg::obd_flash_hs;
            default: flash_mode = obd_pkg::obd_flash_bad;
        endcase
    end

    // Oscillator frequency codes
    always_comb begin
        case (freq_f)
            4'h0: osc_freq = obd_pkg::obd_f24;
            4'h9: osc_freq = obd_pkg::obd_f16;
            4'h1: osc_freq = obd_pkg::obd_f12;
            4'ha: osc_freq = obd_pkg::obd_f8;
            4'hb: osc_freq = obd_pkg::obd_f4;
            4'hd: osc_freq = obd_pkg::obd_f1;
            default: osc_freq = obd_pkg::obd_fbad;
        endcase
    end

    // Low voltage mode cannot run above 8 MHz
    assign over_limit = (flash_mode == obd_pkg::obd_flash_lv) && (osc_freq == obd_pkg::obd_f24
        || osc_freq == obd_pkg::obd_f16 || osc_freq == obd_pkg::obd_f12);
endmodule

// ===== hdl/obd_top.sv
// Option byte loader and decoder with a Wishbone status window
//
// The register offsets and the Wishbone slave port were decided locally.
`timescale 1ns/10ps
`include "obd_consts.svh"
module obd_top (
    input wire logic clk,
    input wire logic rst_n,
    // Option storage read port
    output logic nv_rd_req,
    output logic [7:0] nv_rd_addr,
    input wire logic nv_rd_valid,
    input wire logic [7:0] nv_rd_data,
    // Wishbone slave
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    // Decoded settings
    output logic options_valid,
    output obd_pkg::obd_lvd_mode_type lvd_mode,
    output logic [3:0] lvd_level,
    output logic reset_pin_select,
    output logic reset_pin_pullup_enable,
    output obd_pkg::obd_flash_type flash_mode,
    output obd_pkg::obd_freq_type internal_fast_oscillator,
    output logic debug_enable_set,
    output logic debug_keep_flash_on_auth_fail,
    output logic debug_erase_on_auth_fail
);

    // ****************************************************************
    // Declarations
    // ****************************************************************

    obd_pkg::obd_ld_state_type ld_state_r;
    logic [1:0] ld_idx_r;
    logic [7:0] raw_lvd_r;
    logic [7:0] raw_clk_r;
    logic [7:0] raw_dbg_r;
    logic [7:0] nv_rd_addr_r;
    logic [5:0] err_r;
    logic [5:0] err_set;
    logic [5:0] err_clr;
    logic apply;
    logic wb_req;
    logic [31:0] rd_word;
    logic [31:0] wb_dat_r_r;
    logic wb_ack_r;

    obd_pkg::obd_lvd_mode_type dec_lvd_mode;
    logic [3:0] dec_lvd_level;
    logic dec_lvd_bad;
    obd_pkg::obd_flash_type dec_flash;
    obd_pkg::obd_freq_type dec_freq;
    logic dec_over_limit;
    logic dec_dbg_en;
    logic dec_dbg_keep;
    logic dec_dbg_bad;
    logic dec_fixed_bad;

    logic options_valid_r;
    obd_pkg::obd_lvd_mode_type lvd_mode_r;
    logic [3:0] lvd_level_r;
    logic reset_pin_select_r;
    logic reset_pin_pullup_enable_r;
    obd_pkg::obd_flash_type flash_mode_r;
    obd_pkg::obd_freq_type osc_freq_r;
    logic debug_enable_r;
    logic debug_keep_r;
    logic debug_erase_r;

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Storage address of the byte fetched in a given slot
    function automatic logic [7:0] obd_slot_addr(input logic [1:0] idx);
        case (idx)
            2'h0: obd_slot_addr = `OBD_ADDR_LVD;
            2'h1: obd_slot_addr = `OBD_ADDR_CLK;
            default: obd_slot_addr = `OBD_ADDR_DBG;
        endcase
    endfunction

    // ****************************************************************
    // Option fetch sequence
    // ****************************************************************

    // Request stays up while waiting for the storage to answer
    assign nv_rd_req = (ld_state_r == obd_pkg::obd_ld_fetch);
    assign nv_rd_addr = nv_rd_addr_r;
    assign apply = (ld_state_r == obd_pkg::obd_ld_apply);

    // Fetch three bytes in turn, then apply once and stay done until reset
    // Only a reset leaves the done state, so software can never restart a load
    // The address moves at the end of the gap cycle, ahead of the next request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ld_state_r <= obd_pkg::obd_ld_fetch;
            ld_idx_r <= 2'h0;
        end else begin
            case (ld_state_r)
                obd_pkg::obd_ld_fetch: begin
                    if (nv_rd_valid) begin
                        if (ld_idx_r == 2'h2) begin
                            ld_state_r <= obd_pkg::obd_ld_apply;
                        end else begin
                            ld_state_r <= obd_pkg::obd_ld_gap;
                            ld_idx_r <= ld_idx_r + 2'h1;
                        end
                    end
                end
                obd_pkg::obd_ld_gap: ld_state_r <= obd_pkg::obd_ld_fetch;
                obd_pkg::obd_ld_apply: ld_state_r <= obd_pkg::obd_ld_done;
                obd_pkg::obd_ld_done: ld_state_r <= obd_pkg::obd_ld_done;
                default: ld_state_r <= obd_pkg::obd_ld_done;
            endcase
        end
    end

    // Address follows the slot counter
    // It settles one cycle after the slot moves; the gap cycle with the
    // request low covers that lag
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nv_rd_addr_r <= `OBD_ADDR_LVD;
        end else begin
            nv_rd_addr_r <= obd_slot_addr(ld_idx_r);
        end
    end

    // Raw bytes land in the slot being fetched
    // A valid pulse while the request is low is ignored
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            raw_lvd_r <= `OBD_RAW_RST;
            raw_clk_r <= `OBD_RAW_RST;
            raw_dbg_r <= `OBD_RAW_RST;
        end else if (nv_rd_req && nv_rd_valid) begin
            case (ld_idx_r)
                2'h0: raw_lvd_r <= nv_rd_data;
                2'h1: raw_clk_r <= nv_rd_data;
                default: raw_dbg_r <= nv_rd_data;
            endcase
        end
    end

    // ****************************************************************
    // Field decode
    // ****************************************************************

    // Detector mode and threshold
    obd_lvd_decode u_lvd (
        .opt_byte(raw_lvd_r),
        .lvd_mode(dec_lvd_mode),
        .lvd_level(dec_lvd_level),
        .lvd_bad(dec_lvd_bad)
    );

    // Flash mode and oscillator frequency
    obd_clk_decode u_clk (
        .opt_byte(raw_clk_r),
        .flash_mode(dec_flash),
        .osc_freq(dec_freq),
        .over_limit(dec_over_limit)
    );

    // Debug controls; the prohibited pair leaves debugging off
    // Keep without enable is never trusted: no debug and no keep
    assign dec_dbg_en = raw_dbg_r[`OBD_DBG_EN_BIT];
    assign dec_dbg_keep = raw_dbg_r[`OBD_DBG_KEEP_BIT];
    assign dec_dbg_bad = !dec_dbg_en && dec_dbg_keep;

    // Fixed bits of the clock and debug bytes
    // Wrong fixed bits are only flagged; the fields still decode
    assign dec_fixed_bad = ((raw_clk_r & `OBD_CLK_FIXED_MASK) != `OBD_CLK_FIXED_VAL)
        || ((raw_dbg_r & `OBD_DBG_FIXED_MASK) != `OBD_DBG_FIXED_VAL);

    // ****************************************************************
    // Captured settings
    // ****************************************************************

    // Detector and reset pin, captured once in the apply cycle
    // Reset state is the safe one: detector in reset mode, pin as reset input
    // Pull-up follows the pin select since a reset input must never float
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lvd_mode_r <= obd_pkg::obd_lvd_rst;
            lvd_level_r <= 4'h0;
            reset_pin_select_r <= 1'b1;
            reset_pin_pullup_enable_r <= 1'b1;
        end else if (apply) begin
            lvd_mode_r <= dec_lvd_mode;
            lvd_level_r <= dec_lvd_level;
            reset_pin_select_r <= raw_lvd_r[`OBD_RSTSEL_BIT];
            reset_pin_pullup_enable_r <= raw_lvd_r[`OBD_RSTSEL_BIT];
        end
    end

    // Flash mode and oscillator; prohibited codes fall back to safe values
    // High speed mode with the slowest clock is safe at every supply
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flash_mode_r <= obd_pkg::obd_flash_hs;
            osc_freq_r <= obd_pkg::obd_f1;
        end else if (apply) begin
            if (dec_flash == obd_pkg::obd_flash_bad) begin
                flash_mode_r <= obd_pkg::obd_flash_hs;
            end else begin
                flash_mode_r <= dec_flash;
            end
            if (dec_freq == obd_pkg::obd_fbad || dec_over_limit) begin
                osc_freq_r <= obd_pkg::obd_f1;
            end else begin
                osc_freq_r <= dec_freq;
            end
        end
    end

    // Debug enable and erase policy
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            debug_enable_r <= 1'b0;
            debug_keep_r <= 1'b0;
            debug_erase_r <= 1'b0;
        end else if (apply) begin
            debug_enable_r <= dec_dbg_en;
            debug_keep_r <= dec_dbg_en && dec_dbg_keep;
            debug_erase_r <= dec_dbg_en && !dec_dbg_keep;
        end
    end

    // Settings valid from the cycle after apply
    // Downstream logic must ignore the settings while this is low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            options_valid_r <= 1'b0;
        end else if (apply) begin
            options_valid_r <= 1'b1;
        end
    end

    // Output drive from the captured flops
    // Straight from flops, so no decode glitch reaches the supervisor
    assign options_valid = options_valid_r;
    assign lvd_mode = lvd_mode_r;
    assign lvd_level = lvd_level_r;
    assign reset_pin_select = reset_pin_select_r;
    assign reset_pin_pullup_enable = reset_pin_pullup_enable_r;
    assign flash_mode = flash_mode_r;
    assign internal_fast_oscillator = osc_freq_r;
    assign debug_enable_set = debug_enable_r;
    assign debug_keep_flash_on_auth_fail = debug_keep_r;
    assign debug_erase_on_auth_fail = debug_erase_r;

    // ****************************************************************
    // Sticky error flags
    // ****************************************************************

    // Flags raised once when bad codes are applied
    // Each flag names one kind of prohibited code; apply lasts a single cycle,
    // so a flag is raised once per load
    assign err_set = {6{apply}} & {dec_over_limit, dec_fixed_bad, dec_dbg_bad,
        dec_freq == obd_pkg::obd_fbad, dec_flash == obd_pkg::obd_flash_bad, dec_lvd_bad};

    // Write one to clear through the low byte lane
    // Only lane zero carries the six flags
    assign err_clr = (wb_req && wb_we && wb_sel[0] && wb_adr == `OBD_REG_ERR)
        ? wb_dat_w[5:0] : 6'h00;

    // A set in the clearing cycle wins
    // A fault seen while software clears the flags is never lost
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            err_r <= `OBD_ERR_RST;
        end else begin
            err_r <= (err_r & ~err_clr) | err_set;
        end
    end

    // ****************************************************************
    // Wishbone slave
    // ****************************************************************

    // A request is taken on the first cycle of a strobe
    // The registered ack masks the strobe in its own cycle, so a held
    // strobe is not taken again in the ack cycle, only in the cycle after it
    assign wb_req = wb_cyc && wb_stb && !wb_ack_r;

    // Read word selection; settings registers ignore writes
    // Unmapped offsets read zero
    always_comb begin
        rd_word = 32'h0000_0000;
        case (wb_adr)
            `OBD_REG_STATUS: rd_word = {30'h0, |err_r, options_valid_r};
            `OBD_REG_LVD: rd_word = {24'h0, reset_pin_pullup_enable_r, reset_pin_select_r,
                lvd_level_r, lvd_mode_r};
            `OBD_REG_CLK: rd_word = {27'h0, flash_mode_r, osc_freq_r};
            `OBD_REG_DBG: rd_word = {29'h0, debug_erase_r, debug_keep_r, debug_enable_r};
            `OBD_REG_ERR: rd_word = {26'h0, err_r};
            `OBD_REG_RAW: rd_word = {8'h00, raw_dbg_r, raw_clk_r, raw_lvd_r};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // Acknowledge one cycle after the strobe, data registered with it
    // One wait state: the word is captured at the taking edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_r <= 1'b0;
            wb_dat_r_r <= 32'h0000_0000;
        end else begin
            wb_ack_r <= wb_req;
            if (wb_req && !wb_we) begin
                wb_dat_r_r <= rd_word;
            end
        end
    end

    assign wb_ack = wb_ack_r;
    assign wb_dat_r = wb_dat_r_r;

endmodule

// ===== verif/obd_top_assertions.sv
// Concurrent checks on the option byte decoder ports
`timescale 1ns/10ps
`include "obd_consts.svh"
module obd_top_assertions (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic nv_rd_req,
    input wire logic [7:0] nv_rd_addr,
    input wire logic nv_rd_valid,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_ack,
    input wire logic options_valid,
    input obd_pkg::obd_lvd_mode_type lvd_mode,
    input wire logic [3:0] lvd_level,
    input wire logic reset_pin_select,
    input wire logic reset_pin_pullup_enable,
    input obd_pkg::obd_flash_type flash_mode,
    input obd_pkg::obd_freq_type internal_fast_oscillator,
    input wire logic debug_enable_set,
    input wire logic debug_keep_flash_on_auth_fail,
    input wire logic debug_erase_on_auth_fail
);
    // ********
    // Sequences and properties
    // ********
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence got_s(logic [7:0] a);
        nv_rd_req && nv_rd_valid && nv_rd_addr == a;
    endsequence
    sequence next_fetch_s(logic [7:0] a);
        !nv_rd_req ##1 nv_rd_req && nv_rd_addr == a;
    endsequence
    sequence apply_s;
        !options_valid ##1 options_valid;
    endsequence
    load_done_a: assert property (got_s(`OBD_ADDR_DBG) |=> apply_s)
        else $error("settings not applied after last byte");
    first_gap_a: assert property (got_s(`OBD_ADDR_LVD) |=> next_fetch_s(`OBD_ADDR_CLK))
        else $error("second read address wrong");
    second_gap_a: assert property (got_s(`OBD_ADDR_CLK) |=> next_fetch_s(`OBD_ADDR_DBG))
        else $error("third read address wrong");
    settings_hold_a: assert property (options_valid |=> options_valid && $stable(lvd_mode)
        && $stable(lvd_level) && $stable(internal_fast_oscillator) && $stable(debug_enable_set))
        else $error("settings changed after load");
    no_refetch_a: assert property (options_valid |-> !nv_rd_req)
        else $error("read after load");
    pullup_forced_a: assert property (options_valid
        |-> reset_pin_pullup_enable == reset_pin_select)
        else $error("pull-up not tied to pin select");
    erase_policy_a: assert property (options_valid |-> debug_erase_on_auth_fail
        == (debug_enable_set && !debug_keep_flash_on_auth_fail)) else $error("erase policy wrong");
    keep_needs_en_a: assert property (options_valid && debug_keep_flash_on_auth_fail
        |-> debug_enable_set) else $error("keep without debug enable");
    lv_freq_a: assert property (options_valid && flash_mode == obd_pkg::obd_flash_lv
        |-> internal_fast_oscillator inside {obd_pkg::obd_f8, obd_pkg::obd_f4, obd_pkg::obd_f1})
        else $error("low voltage mode above 8 MHz");
    off_level_a: assert property (options_valid && lvd_mode == obd_pkg::obd_lvd_off
        |-> lvd_level == 4'h0) else $error("level set while detector off");
    ack_pulse_a: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack ##1 !wb_ack)
        else $error("bus answer not one cycle later");
endmodule

bind obd_top obd_top_assertions chk (.clk, .rst_n, .nv_rd_req, .nv_rd_addr, .nv_rd_valid, .wb_cyc,
    .wb_stb, .wb_ack, .options_valid, .lvd_mode, .lvd_level, .reset_pin_select,
    .reset_pin_pullup_enable, .flash_mode, .internal_fast_oscillator, .debug_enable_set,
    .debug_keep_flash_on_auth_fail, .debug_erase_on_auth_fail);

// ===== verif/obd_nv_model.sv
// Option storage model answering reads from three image bytes
`timescale 1ns/10ps
`include "obd_consts.svh"
module obd_nv_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic nv_rd_req,
    input wire logic [7:0] nv_rd_addr,
    input wire logic [7:0] img_lvd,
    input wire logic [7:0] img_clk,
    input wire logic [7:0] img_dbg,
    input wire logic [3:0] dly,
    output logic nv_rd_valid,
    output logic [7:0] nv_rd_data
);
    // ********
    // Read answer
    // ********
    logic [3:0] wait_r;
    // One-cycle answer after a set wait; data scrambles every cycle outside an answer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_r <= 4'h0;
            nv_rd_valid <= 1'b0;
            nv_rd_data <= 8'h5a;
        end else begin
            nv_rd_valid <= 1'b0;
            nv_rd_data <= ~nv_rd_data;
            if (nv_rd_req && !nv_rd_valid && wait_r == dly) begin
                wait_r <= 4'h0;
                nv_rd_valid <= 1'b1;
                nv_rd_data <= (nv_rd_addr == `OBD_ADDR_LVD) ? img_lvd :
                    (nv_rd_addr == `OBD_ADDR_CLK) ? img_clk : img_dbg;
            end else if (nv_rd_req && !nv_rd_valid) begin
                wait_r <= wait_r + 4'h1;
            end
        end
    end
endmodule

// ===== verif/obd_top_tb.sv
// Self-checking bench for the option byte decoder
`timescale 1ns/10ps
`include "obd_consts.svh"
module obd_top_tb;
    // ********
    // Signals and instances
    // ********
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00, img_lvd = 8'h00, img_clk = 8'h00, img_dbg = 8'h00;
    logic [3:0] wb_sel = 4'h0, dly = 4'h0;
    logic [31:0] wb_dat_w = 32'h0, wb_dat_r, q;
    logic nv_rd_req, nv_rd_valid, wb_ack, options_valid, reset_pin_select;
    logic reset_pin_pullup_enable, debug_enable_set, debug_keep_flash_on_auth_fail;
    logic debug_erase_on_auth_fail;
    logic [7:0] nv_rd_addr, nv_rd_data;
    logic [3:0] lvd_level;
    obd_pkg::obd_lvd_mode_type lvd_mode;
    obd_pkg::obd_flash_type flash_mode;
    obd_pkg::obd_freq_type internal_fast_oscillator;
    int error_cnt = 0;
    int cmp_count = 0;

    // Clock at 20 MHz
    always #25 clk = ~clk;

    obd_top dut (.clk, .rst_n, .nv_rd_req, .nv_rd_addr, .nv_rd_valid, .nv_rd_data, .wb_cyc,
        .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_w, .wb_dat_r, .wb_ack, .options_valid,
        .lvd_mode, .lvd_level, .reset_pin_select, .reset_pin_pullup_enable, .flash_mode,
        .internal_fast_oscillator, .debug_enable_set, .debug_keep_flash_on_auth_fail,
        .debug_erase_on_auth_fail);
    obd_nv_model nv (.clk, .rst_n, .nv_rd_req, .nv_rd_addr, .img_lvd, .img_clk, .img_dbg, .dly,
        .nv_rd_valid, .nv_rd_data);

    // ********
    // Tasks
    // ********
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Classic single bus cycle, held until the answer is sampled
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s, output logic [31:0] r);
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat_w <= d;
        wb_sel <= s;
        // Wait as long as it takes; only the watchdog ends a hung cycle
        do begin
            @(posedge clk);
        end while (wb_ack !== 1'b1);
        r = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask

    // Load one image through reset and compare every decoded setting
    task automatic run_case(input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] c3,
        input logic [3:0] d, input logic [1:0] m, input logic [3:0] lv, input logic p,
        input logic [1:0] f, input logic [2:0] o, input logic [2:0] g, input logic [5:0] e);
        int n;
        rst_n <= 1'b0;
        img_lvd <= c1;
        img_clk <= c2;
        img_dbg <= c3;
        dly <= d;
        repeat (5) @(posedge clk);
        check(options_valid, 32'h0);
        check(nv_rd_req, 32'h1);
        rst_n <= 1'b1;
        n = 0;
        while (options_valid !== 1'b1 && n < 60) begin
            @(posedge clk);
            n++;
        end
        check(options_valid, 32'h1);
        check(lvd_mode, m);
        check(lvd_level, lv);
        check(reset_pin_select, p);
        check(reset_pin_pullup_enable, p);
        check(flash_mode, f);
        check(internal_fast_oscillator, o);
        check({debug_erase_on_auth_fail, debug_keep_flash_on_auth_fail,
            debug_enable_set}, g);
        wb(1'b0, `OBD_REG_RAW, 32'h0, 4'hf, q);
        check(q, {8'h00, c3, c2, c1});
        wb(1'b0, `OBD_REG_ERR, 32'h0, 4'hf, q);
        check(q, {26'h0, e});
        wb(1'b0, `OBD_REG_STATUS, 32'h0, 4'hf, q);
        check(q, {30'h0, |e, 1'b1});
        wb(1'b1, `OBD_REG_LVD, 32'hffffffff, 4'hf, q);
        wb(1'b0, `OBD_REG_LVD, 32'h0, 4'hf, q);
        check(q, {24'h0, p, p, lv, m});
        wb(1'b0, `OBD_REG_CLK, 32'h0, 4'hf, q);
        check(q, {27'h0, f, o});
        wb(1'b0, `OBD_REG_DBG, 32'h0, 4'hf, q);
        check(q, {29'h0, g});
        wb(1'b1, `OBD_REG_ERR, 32'h3f, 4'h1, q);
        wb(1'b0, `OBD_REG_ERR, 32'h0, 4'hf, q);
        check(q, 32'h0);
        wb(1'b0, 8'h20, 32'h0, 4'hf, q);
        check(q, 32'h0);
        check(lvd_mode, m);
        $display("Test ends: image %h %h %h", c1, c2, c3);
    endtask

    task automatic stop_test;
        $display("Compares %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ********
    // Tests
    // ********
    // Image rows keep fixed bits and never pair debug off with keep, except row four
    initial begin
        run_case(8'h7f, 8'he0, 8'h85, 4'h0, 2'h3, 4'h8, 1'b1, 2'h1, 3'h0, 3'h3, 6'h00);
        run_case(8'h25, 8'haa, 8'h84, 4'h3, 2'h1, 4'h2, 1'b0, 2'h0, 3'h3, 3'h5, 6'h00);
        run_case(8'h81, 8'hed, 8'h04, 4'h1, 2'h0, 4'h0, 1'b0, 2'h1, 3'h5, 3'h0, 6'h00);
        run_case(8'h02, 8'h2b, 8'h05, 4'h2, 2'h3, 4'h0, 1'b0, 2'h1, 3'h4, 3'h0, 6'h0b);
        run_case(8'h4b, 8'he9, 8'h85, 4'h0, 2'h3, 4'h5, 1'b0, 2'h1, 3'h1, 3'h3, 6'h00);
        run_case(8'h76, 8'he1, 8'h84, 4'h0, 2'h2, 4'ha, 1'b1, 2'h1, 3'h2, 3'h5, 6'h00);
        run_case(8'h7f, 8'ha0, 8'h85, 4'h1, 2'h3, 4'h8, 1'b1, 2'h0, 3'h5, 3'h3, 6'h20);
        stop_test();
    end

    // Watchdog against a hang
    initial begin
        repeat (4000) @(posedge clk);
        error_cnt++;
        stop_test();
    end
endmodule
